// ===== shared/sfg_defs.svh
`ifndef SFG_DEFS_SVH
`define SFG_DEFS_SVH

// ****************************************
// host register map (byte addresses, low 8 bits)
// ****************************************
`define SFG_CTRL 8'h00
`define SFG_ARG 8'h04
`define SFG_CFG 8'h08
`define SFG_STAT 8'h0c
`define SFG_BLK_BASE 2'b01

// ****************************************
// field positions
// ****************************************
`define SFG_GO_BIT 0
`define SFG_MODE_BIT 1
`define SFG_CFG_UHS2_BIT 0
`define SFG_CFG_VDD1_BIT 1
`define SFG_ST_BUSY_BIT 0
`define SFG_ST_DONE_BIT 1
`define SFG_ST_ERR_BIT 2

// ****************************************
// reset values and counts
// ****************************************
`define SFG_ARG_RST 24'hffffff
`define SFG_SEL_RST 24'h000000
`define SFG_LAST_WORD 5'h1f
`define SFG_KEEP 4'hf

// ****************************************
// current figures in ma at 3.6v
// ****************************************
`define SFG_SPD0_MA 16'h0064
`define SFG_SPD1_MA 16'h00c8
`define SFG_SPD2_MA 16'h0190
`define SFG_SPD3_MA 16'h01f4
`define SFG_SPD4_MA 16'h01c2
`define SFG_UHS2_MA 16'h0190
`define SFG_CMDSYS_MA 16'h0032
`define SFG_LIM0_MA 16'h00c8
`define SFG_LIM1_MA 16'h0190
`define SFG_LIM2_MA 16'h0258
`define SFG_LIM3_MA 16'h0320
`define SFG_LIM4_MA 16'h01f4

`endif

// ===== shared/sfg_pkg.sv
package sfg_pkg;

	typedef enum logic [1:0] {
		CS_IDLE = 2'b01,
		CS_SEND = 2'b10
	} sfg_card_st_t;

	typedef enum logic [2:0] {
		HS_IDLE = 3'b001,
		HS_CMD = 3'b010,
		HS_RECV = 3'b100
	} sfg_host_st_t;

	typedef struct packed {
		sfg_card_st_t st;
		logic [5:0][3:0] sel;
		logic [511:0] blk;
		logic [4:0] cnt;
		logic rdy;
		logic dvld;
		logic last;
		logic [3:0] drv;
		logic [3:0] eff;
		logic ext;
		logic fen;
	} sfg_card_s_t;

	typedef struct packed {
		sfg_host_st_t st;
		logic [1:0] cfg;
		logic [23:0] arg;
		logic mode;
		logic busy;
		logic done;
		logic err;
		logic [511:0] blk;
		logic cmd_vld;
		logic [31:0] hrdata;
		logic rdy;
		logic wr_pend;
		logic [7:0] wr_addr;
	} sfg_host_s_t;

endpackage

// ===== shared/sfg_link_if.sv
`timescale 1ns/1ps
interface sfg_link_if;
	logic cmd_vld;
	logic cmd_mode;
	logic [23:0] cmd_arg;
	logic cmd_rdy;
	logic dat_vld;
	logic [15:0] dat;
	logic dat_last;

	modport card (
		input cmd_vld, cmd_mode, cmd_arg,
		output cmd_rdy, dat_vld, dat, dat_last
	);

	modport host (
		output cmd_vld, cmd_mode, cmd_arg,
		input cmd_rdy, dat_vld, dat, dat_last
	);
endinterface

// ===== design/sfg_sync.sv
`timescale 1ns/1ps
module sfg_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_ff;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_ff <= '0;
			q <= '0;
		end else begin
			meta_ff <= d;
			q <= meta_ff;
		end
	end
endmodule

// ===== design/sfg_card.sv
// Function
// - 3.3V signalling offers speed functions 0,1 only
// - 1.8V signalling maps SDR/DDR onto functions 0-4
// - command system governs extended commands 34-37,50,57
// - driver strength acts only under 1.8V signalling
// - power limit starts at function 0, 0.72W
// - underpowered function disabled; others run 0.72W
// - F0, FF supported, F5-FE not; X shared
// - 3.0x card: X zero, UHS F4 zero
// - UHS-I card clamps to 1.44W level
// - power limits 2,3 banned in UHS-II
// - first-rail-only host selects limit 0 or 1
// - UHS-I host raises limit after fast speeds
// - UHS-II host raises limit after initialisation
// - UHS-II ignores groups 1,3; 2 optional; 4 mandatory
// - status block always 512 bits
// - top field holds total maximum current
// - check ignores limit; set honours limit
// - host checks current before set
// - reported current covers newly added functions
// - limit functions 0-4 encode five power levels
// - 0xF keeps function; invalid answers 0xF
// - current field n mA; zero means error
`timescale 1ns/1ps
`include "sfg_defs.svh"
module sfg_card (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// link to host
	sfg_link_if.card lnk,
	// card straps, asynchronous
	input wire logic sig_1v8,
	input wire logic uhs2_mode,
	input wire logic compliant_30,
	input wire logic x_value,
	input wire logic grp2_uhs2,
	// card core, same clock
	input wire logic card_reset,
	input wire logic [5:0] cmd_index,
	input wire logic [3:0] fn_need,
	// selected functions
	output logic [3:0] bus_speed,
	output logic [3:0] cmd_sys,
	output logic [3:0] drv_strength,
	output logic [3:0] pwr_limit,
	output logic [3:0] pwr_eff,
	output logic ext_cmd_route,
	output logic fn_enabled
);
	// ****************************************
	// decode helpers
	// ****************************************
	function automatic logic [15:0] sup_bits(
		input logic [2:0] gi,
		input logic s18,
		input logic u2,
		input logic v30,
		input logic xv,
		input logic g2
	);
		logic [15:0] b;
		b = 16'h8001;
		if (gi < 3'h4) begin
			if (s18 || u2) begin
				b[4:1] = {~v30, 3'h7};
			end else if (!v30) begin
				b[4:1] = {4{xv}};
			end
			if (gi == 3'h0 && !s18 && !u2) begin
				b[4:2] = 3'h0;
			end
			if (gi == 3'h1) begin
				b[2] = 1'b0;
			end
			if (gi == 3'h2) begin
				b[4] = 1'b0;
			end
			if (u2 && (gi == 3'h0 || gi == 3'h2)) begin
				b[4:1] = 4'h0;
			end
			if (u2 && gi == 3'h1 && !g2) begin
				b[4:1] = 4'h0;
			end
			if (u2 && gi == 3'h3) begin
				b[3:2] = 2'h0;
			end
		end
		return b;
	endfunction

	function automatic logic [15:0] lim_ma(input logic [3:0] f);
		case (f)
			4'h0: lim_ma = `SFG_LIM0_MA;
			4'h1: lim_ma = `SFG_LIM1_MA;
			4'h2: lim_ma = `SFG_LIM2_MA;
			4'h3: lim_ma = `SFG_LIM3_MA;
			4'h4: lim_ma = `SFG_LIM4_MA;
			default: lim_ma = `SFG_LIM0_MA;
		endcase
	endfunction

	function automatic logic [15:0] spd_ma(input logic [3:0] f);
		case (f)
			4'h0: spd_ma = `SFG_SPD0_MA;
			4'h1: spd_ma = `SFG_SPD1_MA;
			4'h2: spd_ma = `SFG_SPD2_MA;
			4'h3: spd_ma = `SFG_SPD3_MA;
			4'h4: spd_ma = `SFG_SPD4_MA;
			default: spd_ma = `SFG_SPD0_MA;
		endcase
	endfunction

	// a uhs-i card never exceeds the 1.44w level, whatever is granted
	function automatic logic [3:0] eff_lim(input logic [3:0] f, input logic u2);
		if (!u2 && f > 4'h1 && f < 4'h5) begin
			eff_lim = 4'h1;
		end else begin
			eff_lim = f;
		end
	endfunction

	function automatic logic is_ext(input logic [5:0] idx);
		is_ext = (idx >= 6'h22 && idx <= 6'h25) || idx == 6'h32 || idx == 6'h39;
	endfunction

	// ****************************************
	// strap synchroniser
	// ****************************************
	logic [4:0] strap;
	logic s18;
	logic u2;
	logic v30;
	logic xv;
	logic g2;

	sfg_sync #(.W(5)) u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.d({sig_1v8, uhs2_mode, compliant_30, x_value, grp2_uhs2}),
		.q(strap)
	);

	assign {s18, u2, v30, xv, g2} = strap;

	// ****************************************
	// state
	// ****************************************
	sfg_pkg::sfg_card_s_t s_ff;
	sfg_pkg::sfg_card_s_t nxt_s;
	logic [5:0][3:0] tgt;
	logic [5:0][15:0] sup;
	logic ok;
	logic ign;
	logic [3:0] t;
	logic [15:0] base;
	logic [15:0] lm;
	logic [15:0] ma;
	logic [23:0] res;

	always_comb begin
		nxt_s = s_ff;
		ok = 1'b1;
		ign = 1'b0;
		t = 4'h0;
		tgt = s_ff.sel;
		sup = '0;
		for (int gi = 0; gi < 6; gi++) begin
			sup[gi] = sup_bits(3'(gi), s18, u2, v30, xv, g2);
			t = lnk.cmd_arg[4*gi +: 4];
			ign = u2 && (gi == 0 || gi == 2);
			if (t == `SFG_KEEP || ign) begin
				t = s_ff.sel[gi];
			end
			// an ignored group keeps its function and can never fail the command
			ok = ok & (sup[gi][t] | ign);
			tgt[gi] = t;
		end
		// current covers the added functions; defaults stay in the csd fields
		base = u2 ? `SFG_UHS2_MA : spd_ma(tgt[0]);
		if (tgt[1] != 4'h0) begin
			base = base + `SFG_CMDSYS_MA;
		end
		lm = lim_ma(eff_lim(tgt[3], u2));
		ma = base;
		if (lnk.cmd_mode && base > lm) begin
			ma = lm;
		end
		if (!ok) begin
			ma = 16'h0000;
		end
		res = ok ? tgt : 24'hffffff;
		case (s_ff.st)
			sfg_pkg::CS_IDLE: begin
				if (lnk.cmd_vld) begin
					nxt_s.blk = {ma, sup[5], sup[4], sup[3], sup[2], sup[1], sup[0],
						res, 376'h0};
					if (lnk.cmd_mode && ok) begin
						nxt_s.sel = tgt;
					end
					nxt_s.st = sfg_pkg::CS_SEND;
					nxt_s.rdy = 1'b0;
					nxt_s.dvld = 1'b1;
					nxt_s.cnt = 5'h00;
					nxt_s.last = 1'b0;
				end
			end
			sfg_pkg::CS_SEND: begin
				if (s_ff.cnt == `SFG_LAST_WORD) begin
					nxt_s.st = sfg_pkg::CS_IDLE;
					nxt_s.rdy = 1'b1;
					nxt_s.dvld = 1'b0;
					nxt_s.last = 1'b0;
				end else begin
					nxt_s.blk = {s_ff.blk[495:0], 16'h0000};
					nxt_s.cnt = s_ff.cnt + 5'h01;
					nxt_s.last = (s_ff.cnt == `SFG_LAST_WORD - 5'h01);
				end
			end
			default: begin
				nxt_s.st = sfg_pkg::CS_IDLE;
				nxt_s.rdy = 1'b1;
				nxt_s.dvld = 1'b0;
			end
		endcase
		if (card_reset) begin
			nxt_s.sel = `SFG_SEL_RST;
		end
		nxt_s.drv = s18 ? s_ff.sel[2] : 4'h0;
		nxt_s.eff = eff_lim(s_ff.sel[3], u2);
		nxt_s.ext = (s_ff.sel[1] != 4'h0) && is_ext(cmd_index);
		// functions without an enable method are sized for limit 0 by design
		nxt_s.fen = lim_ma(eff_lim(s_ff.sel[3], u2)) >= lim_ma(fn_need);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_ff.st <= sfg_pkg::CS_IDLE;
			s_ff.sel <= `SFG_SEL_RST;
			s_ff.blk <= '0;
			s_ff.cnt <= 5'h00;
			s_ff.rdy <= 1'b1;
			s_ff.dvld <= 1'b0;
			s_ff.last <= 1'b0;
			s_ff.drv <= 4'h0;
			s_ff.eff <= 4'h0;
			s_ff.ext <= 1'b0;
			s_ff.fen <= 1'b1;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign lnk.cmd_rdy = s_ff.rdy;
	assign lnk.dat_vld = s_ff.dvld;
	assign lnk.dat = s_ff.blk[511:496];
	assign lnk.dat_last = s_ff.last;
	assign bus_speed = s_ff.sel[0];
	assign cmd_sys = s_ff.sel[1];
	assign drv_strength = s_ff.drv;
	assign pwr_limit = s_ff.sel[3];
	assign pwr_eff = s_ff.eff;
	assign ext_cmd_route = s_ff.ext;
	assign fn_enabled = s_ff.fen;
endmodule

// ===== design/sfg_host.sv
`timescale 1ns/1ps
`include "sfg_defs.svh"
module sfg_host (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// link to card
	sfg_link_if.host lnk
);
	sfg_pkg::sfg_host_s_t s_ff;
	sfg_pkg::sfg_host_s_t nxt_s;
	logic ap;
	logic [3:0] pl;
	logic bad;
	logic [3:0] wi;

	always_comb begin
		nxt_s = s_ff;
		ap = hsel && htrans[1] && hready;
		pl = s_ff.arg[15:12];
		// refuse what this host may not ask for rather than trust software
		bad = (s_ff.cfg[`SFG_CFG_UHS2_BIT] && (pl == 4'h2 || pl == 4'h3))
			|| (s_ff.cfg[`SFG_CFG_VDD1_BIT] && pl > 4'h1 && pl != `SFG_KEEP);
		wi = haddr[5:2];
		// ****************************************
		// address phase: reads answer in the next cycle, zero wait
		// ****************************************
		nxt_s.wr_pend = ap && hwrite;
		if (ap) begin
			nxt_s.wr_addr = haddr[7:0];
		end
		if (ap && !hwrite) begin
			nxt_s.hrdata = 32'h00000000;
			if (haddr[7:6] == `SFG_BLK_BASE) begin
				nxt_s.hrdata = s_ff.blk[{4'hf - wi, 5'h00} +: 32];
			end else begin
				case (haddr[7:0])
					`SFG_CTRL: nxt_s.hrdata = {30'h0, s_ff.mode, 1'b0};
					`SFG_ARG: nxt_s.hrdata = {8'h00, s_ff.arg};
					`SFG_CFG: nxt_s.hrdata = {30'h0, s_ff.cfg};
					`SFG_STAT: nxt_s.hrdata = {29'h0, s_ff.err, s_ff.done, s_ff.busy};
					default: nxt_s.hrdata = 32'h00000000;
				endcase
			end
		end
		// ****************************************
		// data phase writes; arg and mode locked while busy
		// ****************************************
		if (s_ff.wr_pend && !s_ff.busy) begin
			case (s_ff.wr_addr)
				`SFG_ARG: nxt_s.arg = hwdata[23:0];
				`SFG_CFG: nxt_s.cfg = hwdata[1:0];
				`SFG_CTRL: begin
					nxt_s.mode = hwdata[`SFG_MODE_BIT];
					if (hwdata[`SFG_GO_BIT]) begin
						nxt_s.done = 1'b0;
						nxt_s.err = 1'b0;
						if (bad) begin
							nxt_s.err = 1'b1;
							nxt_s.done = 1'b1;
						end else begin
							nxt_s.busy = 1'b1;
							nxt_s.cmd_vld = 1'b1;
							nxt_s.st = sfg_pkg::HS_CMD;
						end
					end
				end
				default: begin
				end
			endcase
		end
		case (s_ff.st)
			sfg_pkg::HS_IDLE: begin
			end
			sfg_pkg::HS_CMD: begin
				if (lnk.cmd_rdy) begin
					nxt_s.cmd_vld = 1'b0;
					nxt_s.st = sfg_pkg::HS_RECV;
				end
			end
			sfg_pkg::HS_RECV: begin
				if (lnk.dat_vld) begin
					nxt_s.blk = {s_ff.blk[495:0], lnk.dat};
					if (lnk.dat_last) begin
						nxt_s.busy = 1'b0;
						nxt_s.done = 1'b1;
						nxt_s.st = sfg_pkg::HS_IDLE;
					end
				end
			end
			default: nxt_s.st = sfg_pkg::HS_IDLE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_ff.st <= sfg_pkg::HS_IDLE;
			s_ff.cfg <= 2'h0;
			s_ff.arg <= `SFG_ARG_RST;
			s_ff.mode <= 1'b0;
			s_ff.busy <= 1'b0;
			s_ff.done <= 1'b0;
			s_ff.err <= 1'b0;
			s_ff.blk <= '0;
			s_ff.cmd_vld <= 1'b0;
			s_ff.hrdata <= 32'h00000000;
			s_ff.rdy <= 1'b1;
			s_ff.wr_pend <= 1'b0;
			s_ff.wr_addr <= 8'h00;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// the choice of speed and limit is software's, via ARG
	assign hrdata = s_ff.hrdata;
	assign hreadyout = s_ff.rdy;
	assign hresp = 1'b0;
	assign lnk.cmd_vld = s_ff.cmd_vld;
	assign lnk.cmd_mode = s_ff.mode;
	assign lnk.cmd_arg = s_ff.arg;
endmodule

// ===== tb/sfg_link_asserts.sv
`timescale 1ns/1ps
module sfg_link_asserts (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// link signals
	input wire logic cmd_vld,
	input wire logic cmd_mode,
	input wire logic [23:0] cmd_arg,
	input wire logic cmd_rdy,
	input wire logic dat_vld,
	input wire logic [15:0] dat,
	input wire logic dat_last
);
	typedef struct packed {
		logic [4:0] cnt;
		logic [15:0] cur;
	} sfg_chk_s_t;
	sfg_chk_s_t st_ff;
	sfg_chk_s_t nxt_st;
	// word index of the burst, and the current field kept for the result word
	always_comb begin
		nxt_st = st_ff;
		nxt_st.cnt = dat_vld ? st_ff.cnt + 5'h1 : 5'h0;
		if (dat_vld && st_ff.cnt == 5'h0) begin
			nxt_st.cur = dat;
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_take;
		cmd_vld && cmd_rdy;
	endsequence
	sequence s_open;
		dat_vld && !cmd_rdy ##1 !cmd_vld;
	endsequence
	property p_take;
		s_take |=> s_open;
	endproperty
	a_take: assert property (p_take) else $error("no burst after take");
	property p_hold;
		dat_vld |-> $stable(cmd_arg) && $stable(cmd_mode);
	endproperty
	a_hold: assert property (p_hold) else $error("command moved during burst");
	property p_len;
		dat_last |-> dat_vld && st_ff.cnt == 5'h1f;
	endproperty
	a_len: assert property (p_len) else $error("burst not 32 words");
	property p_close;
		dat_last |=> !dat_vld && !dat_last && cmd_rdy;
	endproperty
	a_close: assert property (p_close) else $error("burst did not close");
	property p_idle;
		!dat_vld |-> cmd_rdy;
	endproperty
	a_idle: assert property (p_idle) else $error("not ready while idle");
	property p_busy;
		dat_vld |-> !cmd_rdy;
	endproperty
	a_busy: assert property (p_busy) else $error("ready during burst");
	property p_support;
		dat_vld && st_ff.cnt inside {[5'h1:5'h6]} |-> dat[15] && dat[0] && dat[14:5] == 10'h0;
	endproperty
	a_support: assert property (p_support) else $error("bad support word");
	property p_fail;
		dat_vld && st_ff.cnt == 5'h7 |-> (st_ff.cur == 16'h0) == (dat == 16'hffff);
	endproperty
	a_fail: assert property (p_fail) else $error("error current and result differ");
	property p_pad;
		dat_vld && st_ff.cnt > 5'h8 |-> dat == 16'h0;
	endproperty
	a_pad: assert property (p_pad) else $error("tail not zero");
endmodule

// ===== tb/tb_switch_function_group_status.sv
`timescale 1ns/1ps
`include "sfg_defs.svh"
module tb_switch_function_group_status;
	// ****
	// bench signals
	// ****
	logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, hreadyout, hresp;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic s18 = 1'h0, u2 = 1'h0, c30 = 1'h0, xv = 1'h1, g2 = 1'h0, crst = 1'h0, ext, fen;
	logic [5:0] cidx = 6'h0;
	logic [3:0] need = 4'h0, spd, csys, drv, plim, peff;
	logic [31:0] w [0:15];
	int n_mismatch = 0;
	int comparisons = 0;
	int n_blk = 0;
	sfg_link_if lnk();
	always #25 hclk = ~hclk;
	always @(posedge hclk) if (lnk.dat_last === 1'h1) n_blk <= n_blk + 1;
	sfg_card sfg_card_inst (.hclk(hclk), .hresetn(hresetn), .lnk(lnk), .sig_1v8(s18),
		.uhs2_mode(u2), .compliant_30(c30), .x_value(xv), .grp2_uhs2(g2), .card_reset(crst),
		.cmd_index(cidx), .fn_need(need), .bus_speed(spd), .cmd_sys(csys), .drv_strength(drv),
		.pwr_limit(plim), .pwr_eff(peff), .ext_cmd_route(ext), .fn_enabled(fen));
	sfg_host sfg_host_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .lnk(lnk));
	sfg_link_asserts sfg_link_asserts_inst (.hclk(hclk), .hresetn(hresetn), .cmd_vld(lnk.cmd_vld),
		.cmd_mode(lnk.cmd_mode), .cmd_arg(lnk.cmd_arg), .cmd_rdy(lnk.cmd_rdy),
		.dat_vld(lnk.dat_vld), .dat(lnk.dat), .dat_last(lnk.dat_last));
	// ****
	// tasks
	// ****
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	// a wait that runs out ends the run as a failure
	task automatic waitrdy();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'h1 && n < 20);
		if (hreadyout !== 1'h1) begin
			n_mismatch++;
			print_verdict();
		end
	endtask
	task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] d,
		output logic [31:0] q);
		hsel <= 1'h1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		waitrdy();
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		waitrdy();
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(a, 1'h1, d, q);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		xfer(a, 1'h0, 32'h0, q);
	endtask
	// issue one switch command and fetch the whole status block
	task automatic cmd(input logic m, input logic [23:0] arg);
		logic [31:0] q;
		int n;
		wr(`SFG_ARG, {8'h0, arg});
		wr(`SFG_CTRL, {30'h0, m, 1'h1});
		n = 0;
		do begin
			rd(`SFG_STAT, q);
			n++;
		end while (q[`SFG_ST_DONE_BIT] !== 1'h1 && n < 30);
		if (n >= 30) begin
			n_mismatch++;
			print_verdict();
		end
		for (int i = 0; i < 16; i++) rd({`SFG_BLK_BASE, i[3:0], 2'h0}, w[i]);
		for (int i = 5; i < 16; i++) chk("pad", 32'h0, w[i]);
	endtask
	// ****
	// main sequence
	// ****
	initial begin
		logic [31:0] q;
		int b;
		repeat (5) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		rd(`SFG_ARG, q);
		chk("arg", 32'h00ffffff, q);
		chk("hresp", 32'h0, {31'h0, hresp});
		rd(8'h20, q);
		chk("unmapped", 32'h0, q);
		chk("pwr_limit", 32'h0, {28'h0, plim});
		cmd(1'h0, 24'h000002);
		chk("w0", 32'h00008001, w[0]);
		chk("w3", 32'h8003ffff, w[3]);
		chk("w4", 32'hff000000, w[4]);
		cmd(1'h0, 24'h000001);
		chk("w0", 32'h00c88001, w[0]);
		chk("w1", 32'h8001801f, w[1]);
		chk("w3", 32'h80030000, w[3]);
		chk("w4", 32'h01000000, w[4]);
		cmd(1'h1, 24'h000100);
		chk("drv", 32'h0, {28'h0, drv});
		$display("test 3v3 done");
		s18 <= 1'h1;
		xv <= 1'h0;
		cmd(1'h1, 24'h000103);
		chk("spd", 32'h3, {28'h0, spd});
		chk("drv", 32'h1, {28'h0, drv});
		chk("w0", 32'h00c88001, w[0]);
		chk("w3", 32'h801f0001, w[3]);
		cmd(1'h0, 24'h000103);
		chk("w0", 32'h01f48001, w[0]);
		cmd(1'h1, 24'h004103);
		chk("w0", 32'h01908001, w[0]);
		chk("peff", 32'h1, {28'h0, peff});
		need <= 4'h1;
		repeat (3) @(posedge hclk);
		chk("fen", 32'h1, {31'h0, fen});
		need <= 4'h2;
		repeat (3) @(posedge hclk);
		chk("fen", 32'h0, {31'h0, fen});
		cmd(1'h1, 24'hffff1f);
		chk("keep", 32'h00134, {20'h0, csys, spd, plim});
		for (int i = 0; i < 8; i++) begin
			cidx <= i[2:0] == 3'h4 ? 6'h32 : i[2:0] == 3'h5 ? 6'h39 : 6'h22 + {3'h0, i[2:0]};
			repeat (2) @(posedge hclk);
			chk("ext", {31'h0, i < 6}, {31'h0, ext});
		end
		cmd(1'h0, 24'h004113);
		chk("w0", 32'h02268001, w[0]);
		$display("test uhs1 done");
		c30 <= 1'h1;
		cmd(1'h0, 24'h0);
		chk("w1", 32'h8001800f, w[1]);
		chk("w3", 32'h800f0000, w[3]);
		s18 <= 1'h0;
		cmd(1'h0, 24'h0);
		chk("w3", 32'h80010000, w[3]);
		$display("test compliant done");
		c30 <= 1'h0;
		u2 <= 1'h1;
		cmd(1'h0, 24'h0);
		chk("w1", 32'h80018013, w[1]);
		chk("w2", 32'h80018001, w[2]);
		g2 <= 1'h1;
		cmd(1'h0, 24'h0);
		chk("w2", 32'h8001801b, w[2]);
		wr(`SFG_CFG, 32'h1);
		b = n_blk;
		cmd(1'h1, 24'hff2fff);
		rd(`SFG_STAT, q);
		chk("stat", 32'h6, q);
		wr(`SFG_CFG, 32'h2);
		cmd(1'h1, 24'hff4fff);
		rd(`SFG_STAT, q);
		chk("stat", 32'h6, q);
		chk("blocks", b, n_blk);
		wr(`SFG_CFG, 32'h1);
		cmd(1'h1, 24'hff4fff);
		chk("peff", 32'h4, {28'h0, peff});
		cmd(1'h1, 24'hfffff1);
		chk("w0", 32'h01c28001, w[0]);
		chk("w4", 32'h13000000, w[4]);
		wr(`SFG_CFG, 32'h0);
		cmd(1'h0, 24'hff2fff);
		chk("w0", 32'h00008001, w[0]);
		chk("w4", 32'hff000000, w[4]);
		$display("test uhs2 done");
		crst <= 1'h1;
		@(posedge hclk);
		crst <= 1'h0;
		repeat (2) @(posedge hclk);
		chk("sel", 32'h0, {24'h0, spd, plim});
		$display("test reset done");
		print_verdict();
	end
endmodule
